// ---- test/oadc_host.sv ----
// Host model that drives convert and serial clock and captures the data pins
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module oadc_host
    import oadc_pkg::*;
(
    // Clock and rate strap view
    clk_sys,
    rate,
    // Pins from the device
    echo_clock,
    serial_out,
    // Pins to the device
    sample_convert_n,
    serial_clock
);
    input wire logic clk_sys;
    input wire logic rate;
    input wire logic echo_clock;
    input wire oadc_pkg::oadc_sdo_t serial_out;
    output logic sample_convert_n = 1'b1;
    output logic serial_clock = 1'b0;
    logic [7:0] cap [0:127];
    logic ecap [0:127];
    logic [7:0] oe_run;
    logic act_run;

    task automatic hold(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // One frame of n data bits, clock still outside it
    task automatic frame(input int n);
        sample_convert_n <= 1'b0;
        hold(4);
        oe_run = serial_out.oe_n;
        act_run = testbench.conv_active;
        for (int i = 0; i < n; i++)
        begin
            if (!rate)
            begin
                serial_clock <= 1'b1;
                hold(4);
            end
            cap[i] = serial_out.data;
            ecap[i] = echo_clock;
            serial_clock <= ~serial_clock;
            hold(4);
        end
        if (serial_clock)
        begin
            serial_clock <= 1'b0;
            hold(4);
        end
        sample_convert_n <= 1'b1;
        hold(5);
    endtask
endmodule

// ---- test/testbench.sv ----
// Self-checking bench of the octal converter readout
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module testbench;
    import oadc_pkg::*;
    typedef struct {logic rate; int n;} oadc_row_t;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ce;
    logic res_valid;
    oadc_frame_t res_frame;
    oadc_straps_t straps;
    logic res_ready;
    logic sample_convert_n;
    logic serial_clock;
    logic echo_clock;
    logic echo_clock_oe_n;
    logic conv_active;
    logic conv_underrun;
    logic io_differential;
    logic io_low_power;
    logic under_seen = 1'b0;
    oadc_sdo_t serial_out;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    oadc_row_t rows [4] = '{'{1'b0, 13}, '{1'b1, 13}, '{1'b0, 105}, '{1'b1, 105}};

    oadc_readout i_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .res_valid(res_valid), .res_ready(res_ready),
        .res_frame(res_frame), .sample_convert_n(sample_convert_n), .serial_clock(serial_clock),
        .straps(straps), .serial_out(serial_out), .echo_clock(echo_clock), .echo_clock_oe_n(echo_clock_oe_n),
        .conv_active(conv_active), .conv_underrun(conv_underrun), .io_differential(io_differential),
        .io_low_power(io_low_power));
    oadc_host i_host (.clk_sys(clk_sys), .rate(straps.rate_select), .echo_clock(echo_clock),
        .serial_out(serial_out), .sample_convert_n(sample_convert_n), .serial_clock(serial_clock));

    always #50 clk_sys = ~clk_sys;

    always @(posedge clk_sys)
    begin
        cycles++;
        if (conv_underrun === 1'b1)
            under_seen <= 1'b1;
        if (cycles == 20000)
        begin
            num_errors++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (num_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic oadc_frame_t mk(input int r);
        oadc_frame_t f;
        for (int c = 0; c < 8; c++)
            f[c] = 13'(32'h2d3 * c + 32'h1a5 * r + 32'h1f01);
        return f;
    endfunction

    function automatic logic [7:0] want(input oadc_frame_t f, input int i);
        logic [7:0] b;
        for (int k = 0; k < 8; k++)
            b[k] = f[(k + i / 13) % 8][12 - i % 13];
        return b;
    endfunction

    task automatic push(input oadc_frame_t f);
        res_frame <= f;
        res_valid <= 1'b1;
        @(posedge clk_sys);
        res_valid <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic run(input oadc_frame_t f, input logic rate, input int n);
        straps.rate_select <= rate;
        push(f);
        i_host.frame(n);
        chk("oe_run", 16'h0, {8'h0, i_host.oe_run});
        for (int i = 0; i < n; i++)
        begin
            chk("data", {8'h0, want(f, i)}, {8'h0, i_host.cap[i]});
            chk("echo", rate ? 16'(i % 2) : 16'h1, {15'h0, i_host.ecap[i]});
        end
        chk("oe_rel", 16'hff, {8'h0, serial_out.oe_n});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        ce <= 1'b1;
        res_valid <= 1'b0;
        res_frame <= '0;
        straps <= '0;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        chk("oe_rst", 16'hff, {8'h0, serial_out.oe_n});
        repeat (4) @(posedge clk_sys);
        foreach (rows[r])
            run(mk(r), rows[r].rate, rows[r].n);
        straps.io_select <= OADC_IO_LVDS;
        push(mk(5));
        i_host.frame(2);
        chk("diff", 16'h1, {15'h0, io_differential});
        chk("oe_diff", 16'hff, {8'h0, i_host.oe_run});
        chk("act_diff", 16'h1, {15'h0, i_host.act_run});
        straps.io_select <= OADC_IO_LVDS_LP;
        i_host.hold(4);
        chk("low_pwr", 16'h1, {15'h0, io_low_power});
        straps <= '{1'b0, 1'b1, OADC_IO_CMOS};
        push(mk(6));
        i_host.frame(2);
        chk("echo_oe", 16'h1, {15'h0, echo_clock_oe_n});
        chk("echo_off", 16'h0, {15'h0, i_host.ecap[0]});
        straps <= '0;
        under_seen <= 1'b0;
        for (int j = 0; j < 9; j++)
            push(mk(10 + j));
        chk("full", 16'h0, {15'h0, res_ready});
        for (int j = 0; j < 8; j++)
        begin
            i_host.frame(1);
            chk("order", {8'h0, want(mk(10 + j), 0)}, {8'h0, i_host.cap[0]});
        end
        chk("no_under", 16'h0, {15'h0, under_seen});
        i_host.frame(1);
        chk("under", 16'h1, {15'h0, under_seen});
        chk("idle_act", 16'h0, {15'h0, conv_active});
        i_host.sample_convert_n <= 1'b0;
        i_host.hold(5);
        rst <= 1'b1;
        i_host.hold(1);
        chk("oe_mid", 16'hff, {8'h0, serial_out.oe_n});
        chk("act_mid", 16'h0, {15'h0, conv_active});
        rst <= 1'b0;
        i_host.hold(4);
        chk("act_rel", 16'h0, {15'h0, conv_active});
        i_host.sample_convert_n <= 1'b1;
        push(mk(20));
        i_host.hold(2);
        i_host.frame(1);
        chk("rst_data", {8'h0, want(mk(20), 0)}, {8'h0, i_host.cap[0]});
        push(mk(21));
        ce <= 1'b0;
        i_host.sample_convert_n <= 1'b0;
        i_host.hold(8);
        chk("ce_hold", 16'h0, {15'h0, conv_active});
        ce <= 1'b1;
        i_host.hold(4);
        chk("ce_run", 16'h1, {15'h0, conv_active});
        chk("ce_data", {8'h0, want(mk(21), 0)}, {8'h0, serial_out.data});
        i_host.sample_convert_n <= 1'b1;
        i_host.hold(5);
        chk("ce_rel", 16'hff, {8'h0, serial_out.oe_n});
        give_verdict();
    end
endmodule

// ---- verilog/oadc_pkg.sv ----
// Shared constants and types of the octal converter readout
package oadc_pkg;
    localparam int OADC_CHANNELS = 8;
    localparam int OADC_RES_BITS = 13;
    localparam int OADC_FIFO_DEPTH = 8;
    localparam int OADC_CLK_PERIOD_NS = 100;
    localparam int OADC_RELEASE_NS = 3;
    localparam int OADC_RELEASE_RAW = OADC_RELEASE_NS / OADC_CLK_PERIOD_NS;
    localparam int OADC_RELEASE_CYC = (OADC_RELEASE_RAW < 1) ? 1 : OADC_RELEASE_RAW;
    localparam logic [3:0] OADC_FIRST_BIT = 4'h0;
    localparam logic [3:0] OADC_LAST_BIT = 4'(OADC_RES_BITS - 1);
    localparam logic [2:0] OADC_OWN_CHAN = 3'h0;
    localparam logic [2:0] OADC_CHAN_STEP = 3'h1;
    localparam logic OADC_ECHO_IDLE = 1'b0;

    typedef logic [OADC_RES_BITS-1:0] oadc_sample_t;
    typedef logic [OADC_CHANNELS-1:0][OADC_RES_BITS-1:0] oadc_frame_t;

    typedef enum logic [1:0]
    {
        OADC_IO_CMOS = 2'b00,
        OADC_IO_LVDS = 2'b01,
        OADC_IO_LVDS_LP = 2'b10
    } oadc_io_t;

    typedef enum logic
    {
        OADC_ACQ = 1'b0,
        OADC_CONV = 1'b1
    } oadc_phase_t;

    typedef struct packed
    {
        logic rate_select;
        logic echo_clock_disable;
        oadc_io_t io_select;
    } oadc_straps_t;

    typedef struct packed
    {
        logic [OADC_CHANNELS-1:0] data;
        logic [OADC_CHANNELS-1:0] oe_n;
    } oadc_sdo_t;
endpackage

// ---- verilog/oadc_readout.sv ----
// Conversion start and serial readout of the octal converter
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module oadc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)(
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed
    {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [CW-1:0] count;
    } oadc_fifo_state_t;

    oadc_fifo_state_t q;
    oadc_fifo_state_t d;
    logic push;
    logic pop;

    assign in_ready = (q.count != CW'(DEPTH));
    assign out_valid = (q.count != '0);
    assign out_data = q.mem[q.rptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        d = q;
        if (push)
        begin
            d.mem[q.wptr] = in_data;
            d.wptr = (q.wptr == AW'(DEPTH - 1)) ? '0 : q.wptr + AW'(1);
        end
        if (pop)
        begin
            d.rptr = (q.rptr == AW'(DEPTH - 1)) ? '0 : q.rptr + AW'(1);
        end
        d.count = q.count + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            q <= '0;
        end
        else if (ce)
        begin
            q <= d;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module oadc_readout #(
    parameter int FIFO_DEPTH = oadc_pkg::OADC_FIFO_DEPTH
)(
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // Results from the converter core
    input wire logic res_valid,
    output logic res_ready,
    input wire oadc_pkg::oadc_frame_t res_frame,
    // Pins from the host
    input wire logic sample_convert_n,
    input wire logic serial_clock,
    // Strap pins
    input wire oadc_pkg::oadc_straps_t straps,
    // Serial data pins
    output oadc_pkg::oadc_sdo_t serial_out,
    // Echo clock pin
    output logic echo_clock,
    output logic echo_clock_oe_n,
    // Status
    output logic conv_active,
    output logic conv_underrun,
    output logic io_differential,
    output logic io_low_power
);
    import oadc_pkg::*;

    typedef struct packed
    {
        logic [1:0] conv_sync;
        logic [1:0] sck_sync;
        oadc_straps_t straps_s1;
        oadc_straps_t straps_s2;
        logic conv_prev;
        logic sck_prev;
        oadc_phase_t phase;
        oadc_frame_t frame;
        logic [3:0] bit_idx;
        logic [2:0] ch_ofs;
        logic [OADC_CHANNELS-1:0] sdo;
        logic drive;
        logic echo;
        logic underrun;
    } oadc_state_t;

    oadc_state_t q;
    oadc_state_t d;
    logic conv_fall;
    logic conv_rise;
    logic sck_fall;
    logic sck_rise;
    logic adv;
    logic fifo_valid;
    oadc_frame_t fifo_data;

    // Bit that channel pin k shows for a given offset and bit index
    function automatic logic pick_bit(
        input oadc_frame_t frame,
        input int k,
        input logic [2:0] ofs,
        input logic [3:0] idx
    );
        logic [2:0] ch;
        ch = 3'(k) + ofs;
        pick_bit = frame[ch][OADC_LAST_BIT - idx];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Result buffer
    oadc_fifo #(
        .WIDTH($bits(oadc_frame_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .in_valid(res_valid),
        .in_ready(res_ready),
        .in_data(res_frame),
        .out_valid(fifo_valid),
        .out_ready(conv_fall),
        .out_data(fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection on synchronised pins
    assign conv_fall = q.conv_prev && !q.conv_sync[1];
    assign conv_rise = !q.conv_prev && q.conv_sync[1];
    assign sck_fall = q.sck_prev && !q.sck_sync[1];
    assign sck_rise = !q.sck_prev && q.sck_sync[1];
    assign adv = (q.phase == OADC_CONV) && (sck_fall || (q.straps_s2.rate_select && sck_rise));

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        d = q;
        d.underrun = 1'b0;
        d.conv_sync = {q.conv_sync[0], sample_convert_n};
        d.sck_sync = {q.sck_sync[0], serial_clock};
        d.straps_s1 = straps;
        d.straps_s2 = q.straps_s1;
        d.conv_prev = q.conv_sync[1];
        d.sck_prev = q.sck_sync[1];
        d.echo = q.straps_s2.echo_clock_disable ? OADC_ECHO_IDLE : q.sck_sync[1];
        if (conv_rise)
        begin
            d.phase = OADC_ACQ;
            d.drive = 1'b0;
        end
        else if (conv_fall)
        begin
            d.phase = OADC_CONV;
            d.frame = fifo_valid ? fifo_data : '0;
            d.underrun = !fifo_valid;
            d.bit_idx = OADC_FIRST_BIT;
            d.ch_ofs = OADC_OWN_CHAN;
            d.drive = (q.straps_s2.io_select == OADC_IO_CMOS);
        end
        else if (adv)
        begin
            if (q.bit_idx == OADC_LAST_BIT)
            begin
                d.bit_idx = OADC_FIRST_BIT;
                d.ch_ofs = q.ch_ofs + OADC_CHAN_STEP;
            end
            else
            begin
                d.bit_idx = q.bit_idx + 4'h1;
            end
        end
        for (int k = 0; k < OADC_CHANNELS; k++)
        begin
            d.sdo[k] = pick_bit(d.frame, k, d.ch_ofs, d.bit_idx);
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            q <= '0;
        end
        else if (ce)
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign serial_out.data = q.sdo;
    assign serial_out.oe_n = {OADC_CHANNELS{!q.drive}};
    assign echo_clock = q.echo;
    assign echo_clock_oe_n = q.straps_s2.echo_clock_disable;
    assign conv_active = (q.phase == OADC_CONV);
    assign conv_underrun = q.underrun;
    assign io_differential = (q.straps_s2.io_select != OADC_IO_CMOS);
    assign io_low_power = (q.straps_s2.io_select == OADC_IO_LVDS_LP);

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    acq_holds_a:
    assert property (ce && q.phase == OADC_ACQ && q.conv_sync[1] |=> q.phase == OADC_ACQ)
        else $error("conversion started while convert high");

    conv_start_a:
    assert property (ce && conv_fall |=> conv_active && q.bit_idx == OADC_FIRST_BIT)
        else $error("convert fall did not start conversion");

    io_indep_a:
    assert property (ce && conv_fall && q.straps_s2.io_select != OADC_IO_CMOS |=> q.phase == OADC_CONV)
        else $error("io select blocked conversion start");

    sdr_hold_a:
    assert property (ce && conv_active && !q.straps_s2.rate_select && sck_rise && !conv_fall
        |=> $stable(q.bit_idx) && $stable(q.ch_ofs))
        else $error("single rate shifted on rising edge");

    ddr_step_a:
    assert property (ce && conv_active && q.straps_s2.rate_select && sck_rise && !conv_fall && !conv_rise
        && q.bit_idx != OADC_LAST_BIT |=> q.bit_idx == $past(q.bit_idx) + 4'h1)
        else $error("double rate missed rising edge");

    echo_copy_a:
    assert property (ce && !q.straps_s2.echo_clock_disable |=> echo_clock == $past(q.sck_sync[1]))
        else $error("echo clock not a copy of serial clock");

    echo_off_a:
    assert property (ce && q.straps_s2.echo_clock_disable && q.straps_s1.echo_clock_disable
        |=> echo_clock_oe_n && !echo_clock)
        else $error("echo clock driven while disabled");

    diff_mode_a:
    assert property (ce && conv_fall && io_differential |=> serial_out.oe_n == '1)
        else $error("single-ended pins driven in differential mode");

    msb_first_a:
    assert property (ce && conv_fall && fifo_valid
        |=> serial_out.data[0] == $past(fifo_data[0][OADC_RES_BITS-1]))
        else $error("first bit is not the sign bit");

    chan_wrap_a:
    assert property (ce && adv && !conv_fall && !conv_rise && q.bit_idx == OADC_LAST_BIT
        |=> q.bit_idx == OADC_FIRST_BIT && q.ch_ofs == $past(q.ch_ofs) + OADC_CHAN_STEP)
        else $error("channel did not advance after last bit");

    release_a:
    assert property (ce && conv_rise |=> serial_out.oe_n == '1)
        else $error("outputs not released after convert rise");

    load_start_a:
    assert property (ce && conv_fall |=> q.ch_ofs == OADC_OWN_CHAN && q.frame == $past(fifo_valid ? fifo_data : '0))
        else $error("result not loaded at conversion start");

    conv_seen_c: cover property (ce && conv_fall && fifo_valid);
    ddr_shift_c: cover property (ce && adv && q.straps_s2.rate_select && sck_rise);
    wrap_seen_c: cover property (ce && adv && q.bit_idx == OADC_LAST_BIT && q.ch_ofs == 3'h7);
    underrun_c: cover property (conv_underrun);
endmodule
